// ===== legacy_irq_mask_priority.v
// Interrupt enable masking and two-level priority selection with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask_map.vh"
// Summary of operation
// R1 - The global gate bit 7 of the enable register blocks every source when 0 and lets each follow its mask when 1.
// R2 - The enable register sits at 0xA8 and each bit can be set, cleared or tested alone.
// R3 - Serial peripheral port requests pass only while enable bit 6 is 1.
// R4 - Timer 2 requests from either low or high overflow flag pass only while enable bit 5 is 1.
// R5 - UART requests pass only while enable bit 4 is 1.
// R6 - Timer 1 overflow requests pass only while enable bit 3 is 1.
// R7 - External line 1 requests pass only while enable bit 2 is 1.
// R8 - Timer 0 overflow requests pass only while enable bit 1 is 1.
// R9 - External line 0 requests pass only while enable bit 0 is 1.
// R10 - The level register sits at 0xB8 with bit access, 0 meaning low level and 1 high level.
// R11 - Level bits map to sources exactly as the enable bits do.
// R12 - Level bit 7 always reads 1 and ignores writes.
// R13 - A high-level request preempts a low-level routine and nothing preempts a high-level routine.
// R14 - Equal-level requests are chosen in fixed order from external line 0 up to the serial peripheral port.
// R15 - Pending requests are sampled and decoded every clock so detection takes one cycle, three for the synchronised external lines.
// R16 - Reset clears all enable bits and all usable level bits.
module legacy_irq_mask_priority (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_irq_line0_pin_n,
  input wire ext_irq_line1_pin_n,
  input wire timer0_overflow_flag,
  input wire timer1_overflow_flag,
  input wire async_serial_port_irq,
  input wire timer2_low_overflow_flag,
  input wire timer2_high_overflow_flag,
  input wire serial_periph_port_irq,
  input wire [1:0] service_cmd,
  output reg irq_request,
  output reg [2:0] irq_source,
  output reg irq_high_level,
  output reg irq_out
);
  // ==========================================================================
  // Source gathering
  // ==========================================================================
  localparam ST_IDLE = 3'b001;
  localparam ST_LOW = 3'b010;
  localparam ST_HIGH = 3'b100;
  wire [1:0] ext_sync;
  reg [7:0] enable_reg;
  reg [6:0] level_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] evt_status_reg;
  reg [2:0] evt_mask_reg;
  reg bit_result_reg;
  reg [6:0] raw_req;
  reg [6:0] gated_req;
  reg [6:0] high_req;
  reg [6:0] low_req;
  reg [6:0] pick_vec;
  reg [2:0] pick_idx;
  reg pick_valid;
  reg pick_high;
  reg [2:0] evt_set;
  reg [7:0] bit_mask;
  integer k;
  pin_sync #(.WIDTH(2)) u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({~ext_irq_line1_pin_n, ~ext_irq_line0_pin_n}),
    .sync_out(ext_sync)
  );
  always @* begin
    raw_req[`EXT_LINE0_BIT] = ext_sync[0];
    raw_req[`TIMER0_BIT] = timer0_overflow_flag;
    raw_req[`EXT_LINE1_BIT] = ext_sync[1];
    raw_req[`TIMER1_BIT] = timer1_overflow_flag;
    raw_req[`UART_BIT] = async_serial_port_irq;
    raw_req[`TIMER2_BIT] = timer2_low_overflow_flag | timer2_high_overflow_flag; // R4
    raw_req[`SPI_PORT_BIT] = serial_periph_port_irq;
  end
  // ==========================================================================
  // Masking and priority decode
  // ==========================================================================
  always @* begin
    gated_req = raw_req & enable_reg[6:0] & {7{enable_reg[`GLOBAL_GATE_BIT]}}; // R1 R3 R4 R5 R6 R7 R8 R9
    high_req = gated_req & level_reg; // R10 R11
    low_req = gated_req & ~level_reg;
    pick_high = |high_req;
    pick_vec = pick_high ? high_req : low_req;
    pick_idx = 3'h0;
    pick_valid = 1'b0;
    for (k = 6; k >= 0; k = k - 1) begin
      if (pick_vec[k]) begin
        pick_idx = k[2:0]; // R14
        pick_valid = 1'b1;
      end
    end
    // A request is offered only when it may preempt what is running.
    case (state_reg)
      ST_IDLE: pick_valid = pick_valid;
      ST_LOW: pick_valid = pick_valid & pick_high; // R13
      ST_HIGH: pick_valid = 1'b0; // R13
      default: pick_valid = 1'b0;
    endcase
  end
  // ==========================================================================
  // Service state
  // ==========================================================================
  always @* begin
    state_next = state_reg;
    evt_set = 3'h0;
    case (state_reg)
      ST_IDLE: begin
        if (service_cmd == `SVC_ACK_HIGH) begin
          state_next = ST_HIGH;
        end else if (service_cmd == `SVC_ACK_LOW) begin
          state_next = ST_LOW;
        end
      end
      ST_LOW: begin
        if (service_cmd == `SVC_ACK_HIGH) begin
          state_next = ST_HIGH;
          evt_set[`EVT_PREEMPT_BIT] = 1'b1;
        end else if (service_cmd == `SVC_RETURN) begin
          state_next = ST_IDLE;
          evt_set[`EVT_RETURN_BIT] = 1'b1;
        end
      end
      ST_HIGH: begin
        if (service_cmd == `SVC_RETURN) begin
          state_next = ST_IDLE;
          evt_set[`EVT_RETURN_BIT] = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    evt_set[`EVT_REQUEST_BIT] = pick_valid & ~irq_request;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      irq_request <= 1'b0;
      irq_source <= 3'h0;
      irq_high_level <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      irq_request <= pick_valid; // R15
      irq_source <= pick_idx; // R15
      irq_high_level <= pick_high;
      irq_out <= |(evt_status_reg & evt_mask_reg);
    end
  end
  // ==========================================================================
  // APB address decode
  // ==========================================================================
  wire apb_write = psel & penable & pwrite & pready;
  wire bit_sel = pwdata[3];
  reg read_hit;
  reg write_hit;
  reg [31:0] read_data;
  reg [2:0] evt_clear;
  always @* begin
    bit_mask = 8'h01 << pwdata[2:0];
  end
  // Read data and the error answer are decided at the setup edge so that they stand with pready.
  always @* begin
    read_hit = 1'b1;
    read_data = 32'h00000000;
    case (paddr)
      `ENABLE_MASK_ADDR: begin
        read_data = {24'h000000, enable_reg};
      end
      `LEVEL_SELECT_ADDR: begin
        read_data = {24'h000000, 1'b1, level_reg}; // R12
      end
      `BIT_RESULT_ADDR: begin
        read_data = {31'h00000000, bit_result_reg};
      end
      `SERVICE_ADDR: begin
        read_data = {26'h0000000, state_reg, irq_request, 2'h0};
      end
      `EVENT_STATUS_ADDR: begin
        read_data = {29'h00000000, evt_status_reg};
      end
      `EVENT_MASK_ADDR: begin
        read_data = {29'h00000000, evt_mask_reg};
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end
  // The bit operation register is write-only and the result and service registers are read-only.
  always @* begin
    write_hit = 1'b0;
    case (paddr)
      `ENABLE_MASK_ADDR: begin
        write_hit = 1'b1;
      end
      `LEVEL_SELECT_ADDR: begin
        write_hit = 1'b1;
      end
      `BIT_OP_ADDR: begin
        write_hit = 1'b1;
      end
      `EVENT_STATUS_ADDR: begin
        write_hit = 1'b1;
      end
      `EVENT_MASK_ADDR: begin
        write_hit = 1'b1;
      end
      default: begin
        write_hit = 1'b0;
      end
    endcase
  end
  // ==========================================================================
  // APB register slave
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `ENABLE_RESET; // R16
      level_reg <= `LEVEL_RESET; // R16
      evt_mask_reg <= 3'h0;
      bit_result_reg <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (apb_write) begin
        case (paddr)
          `ENABLE_MASK_ADDR: enable_reg <= pwdata[7:0]; // R2
          `LEVEL_SELECT_ADDR: level_reg <= pwdata[6:0]; // R10 R12
          `EVENT_MASK_ADDR: evt_mask_reg <= pwdata[2:0];
          `EVENT_STATUS_ADDR: evt_mask_reg <= evt_mask_reg;
          `BIT_OP_ADDR: begin
            case (pwdata[5:4])
              `BIT_OP_SET: begin
                if (bit_sel == `SEL_ENABLE) begin
                  enable_reg <= enable_reg | bit_mask; // R2
                end else begin
                  level_reg <= level_reg | bit_mask[6:0]; // R10 R12
                end
              end
              `BIT_OP_CLEAR: begin
                if (bit_sel == `SEL_ENABLE) begin
                  enable_reg <= enable_reg & ~bit_mask; // R2
                end else begin
                  level_reg <= level_reg & ~bit_mask[6:0];
                end
              end
              `BIT_OP_TEST: begin
                if (bit_sel == `SEL_ENABLE) begin
                  bit_result_reg <= |(enable_reg & bit_mask); // R2
                end else begin
                  bit_result_reg <= |({1'b1, level_reg} & bit_mask); // R12
                end
              end
              default: bit_result_reg <= bit_result_reg;
            endcase
          end
          default: evt_mask_reg <= evt_mask_reg;
        endcase
      end
      // An unmapped address answers with an error and its write falls away.
      if (psel && !penable) begin
        if (pwrite) begin
          pslverr <= ~write_hit;
        end else begin
          prdata <= read_data;
          pslverr <= ~read_hit;
        end
      end
    end
  end
  // ==========================================================================
  // Event status
  // ==========================================================================
  // Only a one written to a status bit clears it.
  always @* begin
    evt_clear = 3'h0;
    if (apb_write && paddr == `EVENT_STATUS_ADDR) begin
      evt_clear = pwdata[2:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_reg <= 3'h0;
    end else begin
      // A new event wins over a clear in the same cycle.
      evt_status_reg <= (evt_status_reg & ~evt_clear) | evt_set;
    end
  end
endmodule // legacy_irq_mask_priority
`default_nettype wire

// ===== irq_mask_map.vh
// Register map, field positions, reset values and codes of the interrupt mask and level block.
`ifndef IRQ_MASK_MAP_VH
`define IRQ_MASK_MAP_VH
`define ENABLE_MASK_ADDR 12'h0a8
`define LEVEL_SELECT_ADDR 12'h0b8
`define BIT_OP_ADDR 12'h0c0
`define BIT_RESULT_ADDR 12'h0c4
`define SERVICE_ADDR 12'h0c8
`define EVENT_STATUS_ADDR 12'h0cc
`define EVENT_MASK_ADDR 12'h0d0
`define GLOBAL_GATE_BIT 7
`define SPI_PORT_BIT 6
`define TIMER2_BIT 5
`define UART_BIT 4
`define TIMER1_BIT 3
`define EXT_LINE1_BIT 2
`define TIMER0_BIT 1
`define EXT_LINE0_BIT 0
`define LEVEL_FIXED_BIT 7
`define ENABLE_RESET 8'h00
`define LEVEL_RESET 7'h00
`define BIT_OP_SET 2'h1
`define BIT_OP_CLEAR 2'h2
`define BIT_OP_TEST 2'h3
`define SEL_ENABLE 1'b0
`define SEL_LEVEL 1'b1
`define SVC_ACK_LOW 2'h1
`define SVC_ACK_HIGH 2'h2
`define SVC_RETURN 2'h3
`define EVT_REQUEST_BIT 0
`define EVT_PREEMPT_BIT 1
`define EVT_RETURN_BIT 2
`define EVT_WIDTH 3
`endif

// ===== pin_sync.v
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 2
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_reg;
endmodule // pin_sync
`default_nettype wire

// ===== irq_checker_assertions.sv
// Port checker of the interrupt mask and level block.
`timescale 1ns/1ps
`default_nettype none
module irq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer0_overflow_flag,
  input wire logic timer2_low_overflow_flag,
  input wire logic timer2_high_overflow_flag,
  input wire logic serial_periph_port_irq,
  input wire logic [1:0] service_cmd,
  input wire logic irq_request,
  input wire logic [2:0] irq_source,
  input wire logic irq_high_level
);
  // ====================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_single_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  zero_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  timer0_cause_a: assert property (irq_request && irq_source == 3'h1 |-> $past(timer0_overflow_flag))
    else $error("timer 0 request without flag");
  timer2_cause_a: assert property (irq_request && irq_source == 3'h5
    |-> $past(timer2_low_overflow_flag || timer2_high_overflow_flag)) else $error("timer 2 request without flag");
  spi_cause_a: assert property (irq_request && irq_source == 3'h6 |-> $past(serial_periph_port_irq))
    else $error("spi request without flag");
  high_block_a: assert property (service_cmd == 2'h2 && irq_request ##1 service_cmd == 2'h0 |=> !irq_request)
    else $error("request during high routine");
  low_only_high_a: assert property (service_cmd == 2'h1 && irq_request ##1 service_cmd == 2'h0
    |=> !irq_request || irq_high_level) else $error("low request during low routine");
endmodule // irq_checker
`default_nettype wire

// ===== cpu_seq_model.sv
// Model of the CPU interrupt sequencer that answers the block.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask_map.vh"
module cpu_seq_model (
  input wire logic pclk,
  input wire logic take,
  input wire logic ret,
  input wire logic irq_request,
  input wire logic irq_high_level,
  output logic [1:0] service_cmd = 2'h0
);
  // ====================
  // Acknowledge at the level shown, or return.
  always @(posedge pclk) begin
    if (take && irq_request) begin
      service_cmd <= irq_high_level ? `SVC_ACK_HIGH : `SVC_ACK_LOW;
    end else begin
      service_cmd <= ret ? `SVC_RETURN : 2'h0;
    end
  end
endmodule // cpu_seq_model
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench of the interrupt mask and level block.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask_map.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, t2h = 0, take = 0, ret = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, irq_request, irq_high_level, irq_out;
  logic [6:0] src = 7'h00;
  logic [2:0] irq_source;
  logic [1:0] service_cmd;
  int n_fail = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  legacy_irq_mask_priority legacy_irq_mask_priority_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_line0_pin_n(~src[0]), .ext_irq_line1_pin_n(~src[2]),
    .timer0_overflow_flag(src[1]), .timer1_overflow_flag(src[3]), .async_serial_port_irq(src[4]),
    .timer2_low_overflow_flag(src[5]), .timer2_high_overflow_flag(t2h), .serial_periph_port_irq(src[6]),
    .service_cmd(service_cmd), .irq_request(irq_request), .irq_source(irq_source),
    .irq_high_level(irq_high_level), .irq_out(irq_out));
  cpu_seq_model cpu_seq_model_i (.pclk(pclk), .take(take), .ret(ret), .irq_request(irq_request),
    .irq_high_level(irq_high_level), .service_cmd(service_cmd));
  // ====================
  // Tasks.
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(nm, rd, exp);
  endtask
  task req(input logic [6:0] s, input logic e, input logic [2:0] es);
    src <= s;
    repeat (5) @(posedge pclk);
    chk("irq_request", irq_request, e);
    if (e) chk("irq_source", irq_source, es);
  endtask
  task cmd(input logic tk, input logic rt);
    take <= tk;
    ret <= rt;
    @(posedge pclk);
    take <= 0;
    ret <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ====================
  // Tests.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rchk("enable", `ENABLE_MASK_ADDR, 32'h0);
    rchk("level", `LEVEL_SELECT_ADDR, 32'h80);
    apb(1, `LEVEL_SELECT_ADDR, 32'h7f);
    rchk("level", `LEVEL_SELECT_ADDR, 32'hff);
    apb(0, 12'h004, 0);
    chk("pslverr", er, 1);
    apb(1, `BIT_OP_ADDR, 32'h17);
    rchk("enable", `ENABLE_MASK_ADDR, 32'h80);
    apb(1, `BIT_OP_ADDR, 32'h37);
    rchk("bit test", `BIT_RESULT_ADDR, 32'h1);
    apb(1, `BIT_OP_ADDR, 32'h27);
    rchk("enable", `ENABLE_MASK_ADDR, 32'h0);
    apb(1, `BIT_OP_ADDR, 32'h2e);
    chk("pslverr", er, 0);
    rchk("level", `LEVEL_SELECT_ADDR, 32'hbf);
    apb(1, `BIT_OP_ADDR, 32'h1f);
    apb(1, `BIT_OP_ADDR, 32'h3e);
    rchk("bit test", `BIT_RESULT_ADDR, 32'h0);
    rchk("level", `LEVEL_SELECT_ADDR, 32'hbf);
    apb(1, 12'h004, 32'hff);
    chk("pslverr", er, 1);
    apb(1, `LEVEL_SELECT_ADDR, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1, `ENABLE_MASK_ADDR, 32'h80 | (32'h1 << i));
      req(7'h7f, 1, i[2:0]);
      apb(1, `ENABLE_MASK_ADDR, 32'hff ^ (32'h1 << i));
      req(7'(1 << i), 0, 0);
      apb(1, `ENABLE_MASK_ADDR, 32'h7f);
      req(7'h7f, 0, 0);
    end
    t2h <= 1;
    apb(1, `ENABLE_MASK_ADDR, 32'ha0);
    req(7'h00, 1, 5);
    t2h <= 0;
    apb(1, `ENABLE_MASK_ADDR, 32'hff);
    req(7'h7f, 1, 0);
    apb(1, `EVENT_STATUS_ADDR, 32'h7);
    apb(1, `EVENT_MASK_ADDR, 32'h1);
    req(7'h00, 0, 0);
    req(7'h7e, 1, 1);
    rchk("event status", `EVENT_STATUS_ADDR, 32'h1);
    chk("irq_out", irq_out, 1);
    apb(1, `EVENT_MASK_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_out", irq_out, 0);
    apb(1, `EVENT_STATUS_ADDR, 32'h1);
    apb(1, `EVENT_MASK_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_out", irq_out, 0);
    cmd(1, 0);
    req(7'h7e, 0, 0);
    apb(1, `LEVEL_SELECT_ADDR, 32'h40);
    req(7'h7e, 1, 6);
    chk("irq_high_level", irq_high_level, 1);
    cmd(1, 0);
    req(7'h7e, 0, 0);
    cmd(0, 1);
    req(7'h7e, 1, 6);
    rchk("event status", `EVENT_STATUS_ADDR, 32'h7);
    rchk("service", `SERVICE_ADDR, 32'hc);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
endmodule // testbench
bind legacy_irq_mask_priority irq_checker irq_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .timer0_overflow_flag(timer0_overflow_flag),
  .timer2_low_overflow_flag(timer2_low_overflow_flag), .timer2_high_overflow_flag(timer2_high_overflow_flag),
  .serial_periph_port_irq(serial_periph_port_irq), .service_cmd(service_cmd), .irq_request(irq_request),
  .irq_source(irq_source), .irq_high_level(irq_high_level));
`default_nettype wire
